// ### bsmc_regs.sv
`timescale 1ns/1ps
`default_nettype none
module bsmc_regs import bsmc_pkg::*; (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [BSMC_ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Power state pins from the sequencer
  input wire logic sleep_req_in,
  input wire logic standby_req_in,
  // Regulator controls
  output logic [5:0] vout_code_out,
  output logic [11:0] vout_mv_out,
  output logic [3:0] switch_mode_out,
  output logic reg_enable_out,
  output logic pfm_force_out,
  output logic current_limit_low_out,
  output logic [1:0] switch_freq_out,
  output logic freq_invalid_out,
  output logic [1:0] phase_clock_out,
  output logic [1:0] scaling_step_out
);
  typedef struct packed {
    logic [7:0] normal_setpoint;
    logic [7:0] standby_setpoint;
    logic [7:0] sleep_setpoint;
    logic [7:0] mode;
    logic [7:0] regulator_config;
    logic sw_sleep;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    bsmc_pwr_t pwr;
    logic [5:0] vout_code;
    logic [11:0] vout_mv;
    logic [3:0] switch_mode;
    logic reg_enable;
    logic pfm_force;
    logic ilim_low;
    logic [1:0] freq;
    logic freq_bad;
    logic [1:0] phase;
    logic [1:0] step;
  } bsmc_regs_t;
  bsmc_regs_t st_reg;
  bsmc_regs_t st_next;
  logic [1:0] pins_stable;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic mapped;
  logic wr_commit;

  // Sequencer pins arrive unsynchronised
  bsmc_sync #(.WIDTH(2)) u_sync (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .async_in({sleep_req_in, standby_req_in}),
    .stable_out(pins_stable)
  );

  assign idx = paddr_in[BSMC_ADDR_W-1:2];
  assign wbyte = pstrb_in[0] ? pwdata_in[7:0] : 8'h00;

  always_comb begin
    st_next = st_reg;
    mapped = 1'b0;
    if (paddr_in[1:0] == 2'b00) begin
      mapped = (idx >= BSMC_IDX_NORMAL) && (idx <= BSMC_IDX_CTRL);
    end
    // Misaligned or unmapped writes are dropped
    wr_commit = psel_in && penable_in && st_reg.pready && pwrite_in && pstrb_in[0] && mapped;
    st_next.pready = 1'b0;
    st_next.pslverr = 1'b0;
    // Zero-wait access: answer in the access cycle after setup
    if (psel_in && !penable_in) begin
      st_next.pready = 1'b1;
      st_next.pslverr = !mapped;
      st_next.prdata = 32'h0000_0000;
      // Upper read bits stay zero
      if (!pwrite_in) begin
        case (idx)
          BSMC_IDX_NORMAL: st_next.prdata[7:0] = st_reg.normal_setpoint;
          BSMC_IDX_STANDBY: st_next.prdata[7:0] = st_reg.standby_setpoint;
          BSMC_IDX_SLEEP: st_next.prdata[7:0] = st_reg.sleep_setpoint;
          BSMC_IDX_MODE: st_next.prdata[7:0] = st_reg.mode;
          BSMC_IDX_CONFIG: st_next.prdata[7:0] = st_reg.regulator_config;
          BSMC_IDX_STATUS: st_next.prdata[1:0] = st_reg.pwr;
          BSMC_IDX_CTRL: st_next.prdata[0] = st_reg.sw_sleep;
          default: st_next.prdata = 32'h0000_0000;
        endcase
      end
    end
    // Write commits at the access edge with pready high
    if (wr_commit) begin
      case (idx)
        BSMC_IDX_NORMAL: st_next.normal_setpoint = wbyte & BSMC_MASK_SETPOINT;
        BSMC_IDX_STANDBY: st_next.standby_setpoint = wbyte & BSMC_MASK_SETPOINT;
        BSMC_IDX_SLEEP: st_next.sleep_setpoint = wbyte & BSMC_MASK_SETPOINT;
        BSMC_IDX_MODE: st_next.mode = wbyte & BSMC_MASK_MODE;
        BSMC_IDX_CONFIG: st_next.regulator_config = wbyte & BSMC_MASK_CONFIG;
        BSMC_IDX_CTRL: st_next.sw_sleep = wbyte[0];
        default: st_next.sw_sleep = st_reg.sw_sleep;
      endcase
    end
    // Sleep outranks standby
    if (pins_stable[1] || st_reg.sw_sleep) begin
      st_next.pwr = BSMC_PWR_SLEEP;
    end else if (pins_stable[0]) begin
      st_next.pwr = BSMC_PWR_STANDBY;
    end else begin
      st_next.pwr = BSMC_PWR_NORMAL;
    end
    case (st_reg.pwr)
      BSMC_PWR_SLEEP: begin
        st_next.vout_code = st_reg.sleep_setpoint[BSMC_SETPOINT_W-1:0];
        st_next.reg_enable = st_reg.mode[BSMC_SLEEP_STATE_BIT];
        st_next.pfm_force = st_reg.mode[BSMC_SLEEP_STATE_BIT];
      end
      BSMC_PWR_STANDBY: begin
        st_next.vout_code = st_reg.standby_setpoint[BSMC_SETPOINT_W-1:0];
        st_next.reg_enable = 1'b1;
        st_next.pfm_force = 1'b0;
      end
      default: begin
        st_next.vout_code = st_reg.normal_setpoint[BSMC_SETPOINT_W-1:0];
        st_next.reg_enable = 1'b1;
        st_next.pfm_force = 1'b0;
      end
    endcase
    st_next.switch_mode = st_reg.mode[BSMC_MODE_LSB +: BSMC_MODE_W];
    // Linear millivolt value, one cycle behind code
    st_next.vout_mv = 12'(BSMC_VOUT_BASE_MV) + 12'(st_reg.vout_code) * 12'(BSMC_VOUT_STEP_MV);
    st_next.ilim_low = st_reg.regulator_config[BSMC_ILIM_BIT];
    st_next.freq = st_reg.regulator_config[BSMC_FREQ_LSB +: 2];
    case (st_next.freq)
      BSMC_FREQ_1MHZ: st_next.freq_bad = 1'b0;
      BSMC_FREQ_2MHZ: st_next.freq_bad = 1'b0;
      BSMC_FREQ_4MHZ: st_next.freq_bad = 1'b0;
      default: st_next.freq_bad = 1'b1;
    endcase
    st_next.phase = st_reg.regulator_config[BSMC_PHASE_LSB +: 2];
    st_next.step = st_reg.regulator_config[BSMC_SPEED_LSB +: 2];
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      // Every field spelled out: some output idle levels are not zero
      st_reg.normal_setpoint <= BSMC_RST_SETPOINT;
      st_reg.standby_setpoint <= BSMC_RST_SETPOINT;
      st_reg.sleep_setpoint <= BSMC_RST_SETPOINT;
      st_reg.mode <= BSMC_RST_MODE;
      st_reg.regulator_config <= BSMC_RST_CONFIG;
      st_reg.sw_sleep <= 1'b0;
      st_reg.prdata <= 32'h0000_0000;
      st_reg.pready <= 1'b0;
      st_reg.pslverr <= 1'b0;
      st_reg.pwr <= BSMC_PWR_NORMAL;
      st_reg.vout_code <= 6'h00;
      st_reg.vout_mv <= 12'(BSMC_VOUT_BASE_MV);
      st_reg.switch_mode <= 4'h0;
      st_reg.reg_enable <= 1'b1;
      st_reg.pfm_force <= 1'b0;
      st_reg.ilim_low <= 1'b0;
      st_reg.freq <= 2'h0;
      st_reg.freq_bad <= 1'b0;
      st_reg.phase <= 2'h0;
      st_reg.step <= 2'h0;
    end else if (clk_en_in) begin
      st_reg <= st_next;
    end
  end

  assign prdata_out = st_reg.prdata;
  assign pready_out = st_reg.pready;
  assign pslverr_out = st_reg.pslverr;
  assign vout_code_out = st_reg.vout_code;
  assign vout_mv_out = st_reg.vout_mv;
  assign switch_mode_out = st_reg.switch_mode;
  assign reg_enable_out = st_reg.reg_enable;
  assign pfm_force_out = st_reg.pfm_force;
  assign current_limit_low_out = st_reg.ilim_low;
  assign switch_freq_out = st_reg.freq;
  assign freq_invalid_out = st_reg.freq_bad;
  assign phase_clock_out = st_reg.phase;
  assign scaling_step_out = st_reg.step;
endmodule : bsmc_regs
`default_nettype wire

// ### bsmc_pkg.sv
package bsmc_pkg;
  // Register indices; the byte address on the bus is four times the index
  localparam logic [7:0] BSMC_IDX_NORMAL = 8'h20;
  localparam logic [7:0] BSMC_IDX_STANDBY = 8'h21;
  localparam logic [7:0] BSMC_IDX_SLEEP = 8'h22;
  localparam logic [7:0] BSMC_IDX_MODE = 8'h23;
  localparam logic [7:0] BSMC_IDX_CONFIG = 8'h24;
  localparam logic [7:0] BSMC_IDX_STATUS = 8'h25;
  localparam logic [7:0] BSMC_IDX_CTRL = 8'h26;
  localparam int BSMC_ADDR_W = 10;
  // Field layout
  localparam int BSMC_SETPOINT_LSB = 0;
  localparam int BSMC_SETPOINT_W = 6;
  localparam int BSMC_MODE_LSB = 0;
  localparam int BSMC_MODE_W = 4;
  localparam int BSMC_SLEEP_STATE_BIT = 5;
  localparam int BSMC_ILIM_BIT = 0;
  localparam int BSMC_FREQ_LSB = 2;
  localparam int BSMC_PHASE_LSB = 4;
  localparam int BSMC_SPEED_LSB = 6;
  // Writable masks
  localparam logic [7:0] BSMC_MASK_SETPOINT = 8'h3F;
  localparam logic [7:0] BSMC_MASK_MODE = 8'h2F;
  localparam logic [7:0] BSMC_MASK_CONFIG = 8'hFF;
  // Reset values
  localparam logic [7:0] BSMC_RST_SETPOINT = 8'h00;
  localparam logic [7:0] BSMC_RST_MODE = 8'h00;
  localparam logic [7:0] BSMC_RST_CONFIG = 8'h00;
  // Frequency codes, set point scale in millivolts
  localparam logic [1:0] BSMC_FREQ_1MHZ = 2'h0;
  localparam logic [1:0] BSMC_FREQ_2MHZ = 2'h1;
  localparam logic [1:0] BSMC_FREQ_4MHZ = 2'h2;
  localparam int BSMC_VOUT_BASE_MV = 300;
  localparam int BSMC_VOUT_STEP_MV = 25;
  typedef enum logic [1:0] {
    BSMC_PWR_NORMAL,
    BSMC_PWR_STANDBY,
    BSMC_PWR_SLEEP
  } bsmc_pwr_t;
endpackage : bsmc_pkg

// ### bsmc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module bsmc_sync import bsmc_pkg::*; #(
  parameter int WIDTH = 2
) (
  // Clock
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] stable_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] stable;
  } bsmc_sync_t;
  bsmc_sync_t st_reg;
  bsmc_sync_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // Accept only once stages two and three agree
    for (int i = 0; i < WIDTH; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.stable[i] = st_reg.s3[i];
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_reg <= '0;
    end else if (clk_en_in) begin
      st_reg <= st_next;
    end
  end

  assign stable_out = st_reg.stable;
endmodule : bsmc_sync
`default_nettype wire

// ### bsmc_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module bsmc_regs_monitor import bsmc_pkg::*; (
  // Clock, reset and APB
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [BSMC_ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // Regulator controls
  input wire logic [5:0] vout_code_out,
  input wire logic [11:0] vout_mv_out,
  input wire logic [3:0] switch_mode_out,
  input wire logic reg_enable_out,
  input wire logic pfm_force_out,
  input wire logic current_limit_low_out,
  input wire logic [1:0] switch_freq_out,
  input wire logic freq_invalid_out,
  input wire logic [1:0] phase_clock_out,
  input wire logic [1:0] scaling_step_out
);
  wire logic wr = psel_in && penable_in && pready_out && pwrite_in && pstrb_in[0];
  wire logic setup = psel_in && !penable_in;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  chk_mode_follow: assert property (
    wr && paddr_in == 10'h08C |-> ##2 switch_mode_out == $past(pwdata_in[3:0], 2))
    else $error("mode output does not follow write");
  chk_sleep_state: assert property (pfm_force_out |-> reg_enable_out)
    else $error("pulse mode forced while output off");
  chk_config_follow: assert property (
    wr && paddr_in == 10'h090 |-> ##2
    {scaling_step_out, phase_clock_out, switch_freq_out, current_limit_low_out}
    == {$past(pwdata_in[7:2], 2), $past(pwdata_in[0], 2)})
    else $error("config outputs do not follow write");
  chk_freq_flag: assert property (freq_invalid_out == (switch_freq_out == 2'h3))
    else $error("frequency flag wrong");
  chk_mv_scale: assert property (
    ##1 vout_mv_out == 12'(BSMC_VOUT_BASE_MV + BSMC_VOUT_STEP_MV * $past(vout_code_out)))
    else $error("millivolt value wrong");
  chk_unused_zero: assert property (
    setup && !pwrite_in && paddr_in == 10'h088 |=> !pslverr_out && prdata_out[31:6] == '0)
    else $error("unused bits not zero");
  chk_unmapped_err: assert property (
    setup && paddr_in == 10'h3FC |=> pslverr_out && prdata_out == 32'h0000_0000)
    else $error("unmapped access not refused");
  chk_pready_once: assert property (setup |=> pready_out ##1 !pready_out)
    else $error("ready not a single cycle after setup");
  chk_misalign_err: assert property (
    setup && paddr_in[1:0] != 2'b00 |=> pslverr_out)
    else $error("misaligned access not refused");
  cover property (wr && paddr_in == 10'h08C);
  cover property ($rose(pfm_force_out));
  cover property (pready_out && pslverr_out);
endmodule : bsmc_regs_monitor
bind bsmc_regs bsmc_regs_monitor bsmc_regs_monitor_inst (.*);
`default_nettype wire

// ### bsmc_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module bsmc_regs_bench import bsmc_pkg::*; ();
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic sleep_req_in = 1'b0, standby_req_in = 1'b0;
  logic [9:0] paddr_in = 10'h000;
  logic [31:0] pwdata_in = 32'h0000_0000, prdata_out, rd;
  logic [3:0] pstrb_in = 4'hF;
  logic pready_out, pslverr_out, reg_enable_out, pfm_force_out, er;
  logic current_limit_low_out, freq_invalid_out;
  logic [5:0] vout_code_out;
  logic [11:0] vout_mv_out;
  logic [3:0] switch_mode_out;
  logic [1:0] switch_freq_out, phase_clock_out, scaling_step_out;
  logic [9:0] adr [5] = '{10'h080, 10'h084, 10'h088, 10'h08C, 10'h090};
  logic [31:0] msk [5] = '{32'h0000_003F, 32'h0000_003F, 32'h0000_003F, 32'h0000_002F,
    32'h0000_00FF};
  int err_count = 0, check_count = 0, cyc = 0;
  bsmc_regs bsmc_regs_inst (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .pstrb_in(pstrb_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .sleep_req_in(sleep_req_in),
    .standby_req_in(standby_req_in),
    .vout_code_out(vout_code_out),
    .vout_mv_out(vout_mv_out),
    .switch_mode_out(switch_mode_out),
    .reg_enable_out(reg_enable_out),
    .pfm_force_out(pfm_force_out),
    .current_limit_low_out(current_limit_low_out),
    .switch_freq_out(switch_freq_out),
    .freq_invalid_out(freq_invalid_out),
    .phase_clock_out(phase_clock_out),
    .scaling_step_out(scaling_step_out)
  );
  initial forever #12.5 core_clk_in = ~core_clk_in;
  task finish_test();
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  // Whole run needs well under a thousand cycles
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      finish_test();
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, s, e);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask : tick
  // Request held until ready is sampled high
  task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    do @(posedge core_clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  initial begin
    tick(8);
    rst_in <= 1'b0;
    chk(vout_mv_out, 32'h0000_012C);
    foreach (adr[i]) begin
      apb(1'b0, adr[i], 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(1'b1, adr[i], 32'hFFFF_FFFF);
      apb(1'b0, adr[i], 32'h0000_0000);
      chk(rd, msk[i]);
    end
    apb(1'b0, 10'h3FC, 32'h0000_0000);
    chk({rd[30:0], er}, 32'h0000_0001);
    // Misaligned write is refused and leaves the sleep set point alone
    apb(1'b1, 10'h089, 32'h0000_0000);
    chk(32'(er), 32'h0000_0001);
    apb(1'b0, 10'h088, 32'h0000_0000);
    chk(rd, 32'h0000_003F);
    for (int f = 0; f < 4; f++) begin
      apb(1'b1, 10'h090, {24'h00_0000, 2'(f), 2'(f), 2'(f), 1'b0, f[0]});
      tick(4);
      chk({scaling_step_out, phase_clock_out, switch_freq_out, freq_invalid_out,
        current_limit_low_out}, {f[1:0], f[1:0], f[1:0], f == 3, f[0]});
    end
    // Lane 0 strobe low must leave config alone
    pstrb_in <= 4'h0;
    apb(1'b1, 10'h090, 32'h0000_0000);
    pstrb_in <= 4'hF;
    apb(1'b0, 10'h090, 32'h0000_0000);
    chk(rd, 32'h0000_00FD);
    apb(1'b1, 10'h080, 32'h0000_000A);
    apb(1'b1, 10'h084, 32'h0000_0014);
    apb(1'b1, 10'h088, 32'h0000_0028);
    apb(1'b1, 10'h08C, 32'h0000_0025);
    tick(5);
    chk({vout_code_out, reg_enable_out, pfm_force_out}, {6'h0A, 2'b10});
    sleep_req_in <= 1'b1;
    tick(10);
    chk({vout_code_out, reg_enable_out, pfm_force_out}, {6'h28, 2'b11});
    chk(vout_mv_out, 32'h0000_0514);
    apb(1'b0, 10'h094, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    apb(1'b1, 10'h08C, 32'h0000_0005);
    tick(5);
    chk({reg_enable_out, pfm_force_out, switch_mode_out}, {2'b00, 4'h5});
    sleep_req_in <= 1'b0;
    standby_req_in <= 1'b1;
    tick(10);
    chk({vout_code_out, reg_enable_out}, {6'h14, 1'b1});
    apb(1'b1, 10'h098, 32'h0000_0001);
    tick(10);
    chk(vout_code_out, 32'h0000_0028);
    apb(1'b1, 10'h098, 32'h0000_0000);
    standby_req_in <= 1'b0;
    tick(10);
    chk(vout_code_out, 32'h0000_000A);
    // Clock enable low freezes everything, the pin synchroniser too
    clk_en_in <= 1'b0;
    sleep_req_in <= 1'b1;
    tick(10);
    chk(vout_code_out, 32'h0000_000A);
    clk_en_in <= 1'b1;
    tick(10);
    chk(vout_code_out, 32'h0000_0028);
    // Second reset in mid-run
    sleep_req_in <= 1'b0;
    rst_in <= 1'b1;
    tick(2);
    rst_in <= 1'b0;
    chk(vout_mv_out, 32'h0000_012C);
    apb(1'b0, 10'h090, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    finish_test();
  end
endmodule : bsmc_regs_bench
`default_nettype wire
